/* include/mpct_params.svh */
// Constants for the microstep phase current table
`ifndef MPCT_PARAMS_SVH
`define MPCT_PARAMS_SVH
`define MPCT_ENTRIES 16
`define MPCT_VAL_W 6
`define MPCT_POS_W 6
`define MPCT_IDX_W 4
`define MPCT_FULL_SCALE 6'h3f
`define MPCT_PEAK_ENTRY 4'hf
`define MPCT_HALF_CYCLE 6'h20
`define MPCT_QUARTER 6'h10
`define MPCT_DEFAULT_TABLE {6'h3f, 6'h3f, 6'h3e, 6'h3c, 6'h3a, 6'h37, 6'h34, 6'h30, \
  6'h2c, 6'h28, 6'h23, 6'h1d, 6'h17, 6'h12, 6'h0b, 6'h05}
`endif

/* include/mpct_pkg.sv */
// Types for the microstep phase current table
`include "mpct_params.svh"
package mpct_pkg;
  typedef logic [`MPCT_VAL_W-1:0] mpct_val_t;
  typedef logic [`MPCT_POS_W-1:0] mpct_pos_t;
  typedef logic [`MPCT_IDX_W-1:0] mpct_idx_t;
  typedef mpct_val_t [`MPCT_ENTRIES-1:0] mpct_table_t;
endpackage

/* logic/mpct_table_store.sv */
// Sixteen-entry profile store with sequential load
`timescale 1ns/1ps
`default_nettype none
`include "mpct_params.svh"
module mpct_table_store
  import mpct_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic load_valid,
  input wire mpct_val_t load_value,
  input wire logic load_restart,
  output mpct_table_t table_q,
  output mpct_idx_t load_index
);
  typedef struct packed {
    mpct_table_t tbl;
    mpct_idx_t idx;
  } mpct_store_t;
  mpct_store_t st;
  mpct_store_t next_st;

  // Each write lands at the next index unless a restart in the same cycle drops it; index wraps after entry 15
  always_comb begin
    next_st = st;
    if (load_restart) begin
      next_st.idx = '0;
    end else if (load_valid) begin
      next_st.tbl[st.idx] = load_value;
      next_st.idx = st.idx + 4'h1;
    end
  end

  // Defaults stand until the host reprograms
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st.tbl <= `MPCT_DEFAULT_TABLE;
      st.idx <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign table_q = st.tbl;
  assign load_index = st.idx;

  property p_store_write;
    @(posedge clk) disable iff (rst)
      (load_valid && !load_restart) |=> (table_q[$past(load_index)] == $past(load_value));
  endproperty
  a_store_write: assert property (p_store_write) else $error("entry not stored");

  property p_store_order;
    @(posedge clk) disable iff (rst)
      (load_valid && !load_restart) |=> (load_index == $past(load_index) + 4'h1);
  endproperty
  a_store_order: assert property (p_store_order) else $error("load index not advanced");

  c_store_full: cover property (@(posedge clk) disable iff (rst) load_valid && load_index == 4'hf);
endmodule // mpct_table_store
`default_nettype wire

/* logic/mpct_phase_map.sv */
// Maps a step position onto an entry index, zero flag and direction
`timescale 1ns/1ps
`default_nettype none
`include "mpct_params.svh"
module mpct_phase_map
  import mpct_pkg::*;
(
  input wire mpct_pos_t pos,
  output mpct_idx_t entry_idx,
  output logic zero,
  output logic reverse
);
  logic [4:0] q;
  logic [4:0] fold;

  // Fold the half cycle about its peak, then pick entry n-1
  always_comb begin
    q = pos[4:0];
    reverse = pos[5];
    zero = (q == 5'h00);
    fold = q[4] ? (5'h00 - q) : q;
    if (q == 5'h10) begin
      entry_idx = `MPCT_PEAK_ENTRY;
    end else begin
      entry_idx = fold[3:0] - 4'h1;
    end
  end
endmodule // mpct_phase_map
`default_nettype wire

/* logic/mpct_current_table.sv */
// Top of the microstep phase current table lookup
`timescale 1ns/1ps
`default_nettype none
`include "mpct_params.svh"
module mpct_current_table
  import mpct_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic load_valid,
  input wire mpct_val_t load_value,
  input wire logic load_restart,
  input wire mpct_pos_t step_pos,
  output mpct_val_t mag_a,
  output logic dir_a_rev,
  output mpct_val_t mag_b,
  output logic dir_b_rev,
  output logic full_scale_a,
  output logic full_scale_b
);
  // ==========================================================
  // Storage and mapping
  mpct_table_t table_q;
  mpct_idx_t load_index;
  mpct_pos_t pos_b;
  mpct_idx_t idx_a;
  mpct_idx_t idx_b;
  logic zero_a;
  logic zero_b;
  logic rev_a;
  logic rev_b;

  mpct_table_store u_store (
    .clk(clk),
    .rst(rst),
    .load_valid(load_valid),
    .load_value(load_value),
    .load_restart(load_restart),
    .table_q(table_q),
    .load_index(load_index)
  );

  // Phase B leads by a quarter cycle; wrap is natural in six bits
  assign pos_b = step_pos + `MPCT_QUARTER;

  mpct_phase_map u_map_a (
    .pos(step_pos),
    .entry_idx(idx_a),
    .zero(zero_a),
    .reverse(rev_a)
  );

  mpct_phase_map u_map_b (
    .pos(pos_b),
    .entry_idx(idx_b),
    .zero(zero_b),
    .reverse(rev_b)
  );

  // ==========================================================
  // Registered outputs
  typedef struct packed {
    mpct_val_t ma;
    logic ra;
    mpct_val_t mb;
    logic rb;
    logic fa;
    logic fb;
  } mpct_out_t;
  mpct_out_t st;
  mpct_out_t next_st;

  // Magnitude is never negated; only direction flips
  always_comb begin
    next_st.ma = zero_a ? '0 : table_q[idx_a];
    next_st.ra = rev_a;
    next_st.mb = zero_b ? '0 : table_q[idx_b];
    next_st.rb = rev_b;
    next_st.fa = (next_st.ma == `MPCT_FULL_SCALE);
    next_st.fb = (next_st.mb == `MPCT_FULL_SCALE);
  end

  // One cycle of lookup latency keeps outputs glitch free
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign mag_a = st.ma;
  assign dir_a_rev = st.ra;
  assign mag_b = st.mb;
  assign dir_b_rev = st.rb;
  assign full_scale_a = st.fa;
  assign full_scale_b = st.fb;

  // ==========================================================
  // Checks
  property p_zero_a;
    @(posedge clk) disable iff (rst)
      (step_pos[4:0] == 5'h00) |=> (mag_a == 6'h00);
  endproperty
  a_zero_a: assert property (p_zero_a) else $error("phase A not zero at crossing");

  property p_zero_b;
    @(posedge clk) disable iff (rst)
      (step_pos[4:0] == 5'h10) |=> (mag_b == 6'h00);
  endproperty
  a_zero_b: assert property (p_zero_b) else $error("phase B not zero at crossing");

  property p_peak_a;
    @(posedge clk) disable iff (rst)
      (step_pos[4:0] == 5'h10) |=> (mag_a == $past(table_q[15]));
  endproperty
  a_peak_a: assert property (p_peak_a) else $error("phase A peak wrong");

  property p_low_a;
    @(posedge clk) disable iff (rst)
      (step_pos[4] == 1'b0 && step_pos[3:0] != 4'h0) |=> (mag_a == $past(table_q[step_pos[3:0] - 4'h1]));
  endproperty
  a_low_a: assert property (p_low_a) else $error("phase A rising entry wrong");

  property p_mirror_a;
    @(posedge clk) disable iff (rst)
      (step_pos[4] && step_pos[3:0] != 4'h0) |=> (mag_a == $past(table_q[4'hf - step_pos[3:0]]));
  endproperty
  a_mirror_a: assert property (p_mirror_a) else $error("phase A mirror wrong");

  property p_dir_a;
    @(posedge clk) disable iff (rst)
      1'b1 |=> (dir_a_rev == $past(step_pos[5]));
  endproperty
  a_dir_a: assert property (p_dir_a) else $error("phase A direction wrong");

  property p_shift_b;
    @(posedge clk) disable iff (rst)
      (step_pos == 6'h00) |=> (mag_b == $past(table_q[15]) && !dir_b_rev);
  endproperty
  a_shift_b: assert property (p_shift_b) else $error("phase B shift wrong");

  property p_full;
    @(posedge clk) disable iff (rst)
      1'b1 |-> (full_scale_a == (mag_a == 6'h3f));
  endproperty
  a_full: assert property (p_full) else $error("full scale flag wrong");

  // Phase B rising quarter takes entry n-1 of its own shifted position
  property p_low_b;
    @(posedge clk) disable iff (rst)
      (pos_b[4] == 1'b0 && pos_b[3:0] != 4'h0) |=> (mag_b == $past(table_q[pos_b[3:0] - 4'h1]));
  endproperty
  a_low_b: assert property (p_low_b) else $error("phase B rising entry wrong");

  // Phase B falling quarter mirrors about its peak
  property p_mirror_b;
    @(posedge clk) disable iff (rst)
      (pos_b[4] && pos_b[3:0] != 4'h0) |=> (mag_b == $past(table_q[4'hf - pos_b[3:0]]));
  endproperty
  a_mirror_b: assert property (p_mirror_b) else $error("phase B mirror wrong");

  // Peak entry also lands on phase B at its own peaks
  property p_peak_b;
    @(posedge clk) disable iff (rst)
      (step_pos[4:0] == 5'h00) |=> (mag_b == $past(table_q[15]));
  endproperty
  a_peak_b: assert property (p_peak_b) else $error("phase B peak wrong");

  // Direction of phase B follows the upper half of its shifted position
  property p_dir_b;
    @(posedge clk) disable iff (rst)
      1'b1 |=> (dir_b_rev == $past(pos_b[5]));
  endproperty
  a_dir_b: assert property (p_dir_b) else $error("phase B direction wrong");

  property p_full_b;
    @(posedge clk) disable iff (rst)
      1'b1 |-> (full_scale_b == (mag_b == 6'h3f));
  endproperty
  a_full_b: assert property (p_full_b) else $error("phase B full scale flag wrong");

  c_rev: cover property (@(posedge clk) disable iff (rst) dir_a_rev && mag_a != 6'h00);
  c_peak: cover property (@(posedge clk) disable iff (rst) full_scale_b);
  c_load: cover property (@(posedge clk) disable iff (rst) load_valid);
endmodule // mpct_current_table
`default_nettype wire

/* bench/mpct_host_model.sv */
// Host model that loads the profile table one entry per cycle
`timescale 1ns/1ps
`default_nettype none
module mpct_host_model
  import mpct_pkg::*;
(
  input wire logic clk,
  output logic load_valid,
  output mpct_val_t load_value,
  output logic load_restart
);
  // =====================================
  // Driver
  // Idle state at time zero
  initial begin
    load_valid = 1'b0;
    load_value = 6'h00;
    load_restart = 1'b0;
  end
  // One entry per edge, held until the storing edge; back to back when more follow
  task automatic send(input mpct_val_t v, input bit more);
    load_valid = 1'b1;
    load_value = v;
    @(posedge clk);
    #1;
    if (!more) begin
      load_valid = 1'b0;
      load_value = ~v; // Stale data is not left on an idle line
    end
  endtask
  // Resync the write index to entry zero
  task automatic restart();
    load_restart = 1'b1;
    @(posedge clk);
    #1;
    load_restart = 1'b0;
  endtask
endmodule // mpct_host_model
`default_nettype wire

/* bench/tb_mpct_current_table.sv */
// Self-checking bench for the microstep phase current table
`timescale 1ns/1ps
`default_nettype none
module tb_mpct_current_table
  import mpct_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic load_valid, load_restart, dir_a_rev, dir_b_rev, full_scale_a, full_scale_b;
  mpct_val_t load_value, mag_a, mag_b;
  mpct_pos_t step_pos = 6'h00;
  int tbl[16];
  int widx;
  int seed = 37989;
  int miscompares = 0;
  int n_compared = 0;
  int defs[16] = '{5, 11, 18, 23, 29, 35, 40, 44, 48, 52, 55, 58, 60, 62, 63, 63};

  mpct_current_table i_mpct_current_table (.clk(clk), .rst(rst), .load_valid(load_valid),
    .load_value(load_value), .load_restart(load_restart), .step_pos(step_pos), .mag_a(mag_a),
    .dir_a_rev(dir_a_rev), .mag_b(mag_b), .dir_b_rev(dir_b_rev), .full_scale_a(full_scale_a),
    .full_scale_b(full_scale_b));
  mpct_host_model i_mpct_host_model (.clk(clk), .load_valid(load_valid), .load_value(load_value),
    .load_restart(load_restart));

  // =====================================
  // Clock, model and checks
  always #25 clk = ~clk;

  task automatic end_sim();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
    n_compared++;
    if (seen !== expv) begin
      miscompares++;
      $display("BAD %0t lookup %h expected %h", $time, seen, expv);
    end
  endtask

  // Reference: fold into a half cycle, mirror about the peak, sign from the half
  function automatic logic [15:0] model(input int p);
    int q;
    int m;
    q = p % 32;
    m = (q == 0) ? 0 : (q == 16) ? tbl[15] : (q < 16) ? tbl[q - 1] : tbl[31 - q];
    return {7'(0), 1'(m == 63), 1'(p >= 32), 6'(m)};
  endfunction

  // Present one position and check both phases one edge later
  task automatic look(input int p);
    step_pos = 6'(p);
    @(posedge clk);
    #1;
    chk({7'(0), full_scale_a, dir_a_rev, mag_a}, model(p));
    chk({7'(0), full_scale_b, dir_b_rev, mag_b}, model((p + 16) % 64));
  endtask

  task automatic sweep();
    for (int p = 0; p < 64; p++) begin
      look(p);
    end
  endtask

  // Random values written in order, index wrapping after sixteen
  task automatic load(input int n);
    mpct_val_t v;
    for (int i = 0; i < n; i++) begin
      v = 6'($random(seed));
      tbl[widx] = v;
      widx = (widx + 1) % 16;
      i_mpct_host_model.send(v, i < n - 1);
    end
  endtask

  task automatic do_reset();
    rst = 1'b1;
    tbl = defs;
    widx = 0;
    repeat (16) @(posedge clk);
    chk({6'(0), full_scale_a, dir_a_rev, mag_a, full_scale_b, dir_b_rev}, 16'h0000);
    chk({10'(0), mag_b}, 16'h0000);
    #1;
    rst = 1'b0;
  endtask

  // Watchdog: the whole run is far below this span
  initial begin
    #(20000 * 50);
    miscompares++;
    end_sim();
  end

  initial begin
    do_reset();
    sweep();
    load(16);
    sweep();
    load(5);
    i_mpct_host_model.restart();
    widx = 0;
    load(17);
    for (int i = 0; i < 64; i++) begin
      look($unsigned($random(seed)) % 64);
    end
    do_reset();
    sweep();
    end_sim();
  end
endmodule // tb_mpct_current_table
`default_nettype wire
